// ===== hw/timer16_regs.vh
// Register map, field positions and mode codes of the 16-bit PWM timer
`ifndef TIMER16_REGS_VH
`define TIMER16_REGS_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_COUNT 8'h04
`define REG_CMP_A 8'h08
`define REG_CMP_B 8'h0C
`define REG_CAP_TOP 8'h10
`define REG_FLAGS 8'h14

// Control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 3
`define CTRL_OMA_LSB 4
`define CTRL_OMA_MSB 5
`define CTRL_OMB_LSB 6
`define CTRL_OMB_MSB 7
`define CTRL_PRE_LSB 8
`define CTRL_PRE_MSB 10
`define CTRL_DIR_A 12
`define CTRL_DIR_B 13
`define CTRL_RESET 14'h0000

// Flag register bits
`define FLAG_OVF 0
`define FLAG_MATCH_A 1
`define FLAG_MATCH_B 2
`define FLAG_CAPTURE 3

// Waveform mode codes
`define MODE_CTC_CMP 4'h4
`define MODE_FPWM_8 4'h5
`define MODE_FPWM_9 4'h6
`define MODE_FPWM_10 4'h7
`define MODE_CTC_CAP 4'hC
`define MODE_FPWM_CAP 4'hE
`define MODE_FPWM_CMP 4'hF

// Fixed TOP values and counter limits
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`define COUNT_MAX 16'hFFFF
`define COUNT_ZERO 16'h0000

// Output mode codes
`define OM_NONE 2'h0
`define OM_TOGGLE 2'h1
`define OM_CLEAR 2'h2
`define OM_SET 2'h3

// Prescale select codes and divider terminal counts
`define PRE_STOP 3'h0
`define PRE_DIV1 3'h1
`define PRE_DIV8 3'h2
`define PRE_DIV64 3'h3
`define PRE_DIV256 3'h4
`define PRE_DIV1024 3'h5
`define DIV_8_LAST 10'h007
`define DIV_64_LAST 10'h03F
`define DIV_256_LAST 10'h0FF
`define DIV_1024_LAST 10'h3FF

`endif

// ===== hw/timer_prescaler.v
// Prescaler making the one-cycle timer tick enable
`timescale 1ns/1ps
`include "timer16_regs.vh"

module timer_prescaler (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // Divide select
  input wire [2:0] sel_i,
  // Timer clock enable
  output reg tick_o
);

  reg [9:0] div_q;
  reg [9:0] last;

  // Terminal count of the free-running divider for the chosen ratio
  always @* begin
    case (sel_i)
      `PRE_DIV8: last = `DIV_8_LAST;
      `PRE_DIV64: last = `DIV_64_LAST;
      `PRE_DIV256: last = `DIV_256_LAST;
      `PRE_DIV1024: last = `DIV_1024_LAST;
      default: last = 10'h000;
    endcase
  end

  // Divider and tick; stopped select gives no tick at all
  always @(posedge clock_i) begin
    if (rst_i) begin
      div_q <= 10'h000;
      tick_o <= 1'b0;
    end else if (sel_i == `PRE_STOP || sel_i > `PRE_DIV1024) begin
      div_q <= 10'h000;
      tick_o <= 1'b0;
    end else if (sel_i == `PRE_DIV1) begin
      div_q <= 10'h000;
      tick_o <= 1'b1; // RQ19
    end else if (div_q >= last) begin
      div_q <= 10'h000;
      tick_o <= 1'b1; // RQ19
    end else begin
      div_q <= div_q + 10'h001;
      tick_o <= 1'b0;
    end
  end

endmodule

// ===== hw/timer16_ctc_fast_pwm.v
// 16-bit timer: clear-on-match and fast PWM waveform generation, APB regs
//
// Contract
// RQ1 - Clear-on-match: counter zeroes at TOP from compare A or capture.
// RQ2 - Clear-on-match: reaching TOP sets match A or capture flag.
// RQ3 - Clear-on-match TOP unbuffered; TOP below count wraps via FFFF.
// RQ4 - Clear-on-match, out mode 1: output A toggles on every match.
// RQ5 - Pin shows wave state only while its direction bit selects output.
// RQ6 - Clear-on-match: overflow flag sets when counter rolls FFFF to zero.
// RQ7 - Fast PWM modes 5, 6, 7 use TOP 00FF, 01FF, 03FF.
// RQ8 - Fast PWM E/F take TOP from capture/compare A; clear after TOP.
// RQ9 - Non-inverting clears on match, sets at BOTTOM; inverting opposite.
// RQ10 - Out mode 2 and 3 pick the PWM polarities.
// RQ11 - Fast PWM: overflow at TOP, plus match A or capture flag then.
// RQ12 - With fixed TOP, compare writes mask bits above resolution.
// RQ13 - Fast PWM capture TOP unbuffered; low write wraps counter via FFFF.
// RQ14 - Fast PWM: compare writes go to buffer, loaded when count hits TOP.
// RQ15 - Compare zero gives one-tick spike; compare at TOP a constant level.
// RQ16 - Fast PWM toggle of output A only in mode F.
// RQ17 - Software keeps new TOP at or above every compare value.
// RQ18 - Software keeps register TOP at least 0003.
// RQ19 - Timer tick is clock divided by 1, 8, 64, 256 or 1024.
// RQ20 - Match flag sets one timer cycle after equality; write one clears. Match A at a TOP from compare A sets on the equality tick here.
// RQ21 - Reset forces the wave output state to zero.
// RQ22 - Out mode zero takes no action at matches.
// RQ23 - Software gives the compare value as one 16-bit write.
// RQ24 - Other mode codes leave counter and outputs alone.
// RQ25 - Counter, flags and buffers move only on timer ticks.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "timer16_regs.vh"

module timer16_ctc_fast_pwm (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Compare output pins
  output reg wave_pin_a_o,
  output reg wave_pin_a_oe_o,
  output reg wave_pin_b_o,
  output reg wave_pin_b_oe_o
);

  reg [13:0] ctrl_q;
  reg [15:0] count_value_q;
  reg [15:0] cmp_a_buf_q;
  reg [15:0] cmp_b_buf_q;
  reg [15:0] cmp_a_act_q;
  reg [15:0] cmp_b_act_q;
  reg [15:0] capture_top_value_q;
  reg overflow_flag_q;
  reg match_a_flag_q;
  reg match_b_flag_q;
  reg capture_flag_q;
  reg match_a_pend_q;
  reg match_b_pend_q;
  reg wave_out_a_q;
  reg wave_out_b_q;

  wire tick;
  wire [3:0] waveform_mode_sel;
  wire [1:0] out_mode_a;
  wire [1:0] out_mode_b;
  wire pin_dir_a;
  wire pin_dir_b;

  assign waveform_mode_sel = ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  assign out_mode_a = ctrl_q[`CTRL_OMA_MSB:`CTRL_OMA_LSB];
  assign out_mode_b = ctrl_q[`CTRL_OMB_MSB:`CTRL_OMB_LSB];
  assign pin_dir_a = ctrl_q[`CTRL_DIR_A];
  assign pin_dir_b = ctrl_q[`CTRL_DIR_B];

  // Timer clock enable from the shared divider
  timer_prescaler u_prescaler (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .sel_i(ctrl_q[`CTRL_PRE_MSB:`CTRL_PRE_LSB]),
    .tick_o(tick)
  );

  // Mode decode
  reg ctc_mode;
  reg fpwm_mode;
  reg fixed_top;
  reg [15:0] top;
  always @* begin
    ctc_mode = 1'b0;
    fpwm_mode = 1'b0;
    fixed_top = 1'b0;
    top = `COUNT_MAX;
    case (waveform_mode_sel)
      `MODE_CTC_CMP: begin
        ctc_mode = 1'b1;
        top = cmp_a_act_q; // RQ1
      end
      `MODE_CTC_CAP: begin
        ctc_mode = 1'b1;
        top = capture_top_value_q; // RQ1
      end
      `MODE_FPWM_8: begin
        fpwm_mode = 1'b1;
        fixed_top = 1'b1;
        top = `TOP_8BIT; // RQ7
      end
      `MODE_FPWM_9: begin
        fpwm_mode = 1'b1;
        fixed_top = 1'b1;
        top = `TOP_9BIT; // RQ7
      end
      `MODE_FPWM_10: begin
        fpwm_mode = 1'b1;
        fixed_top = 1'b1;
        top = `TOP_10BIT; // RQ7
      end
      `MODE_FPWM_CAP: begin
        fpwm_mode = 1'b1;
        top = capture_top_value_q; // RQ8
      end
      `MODE_FPWM_CMP: begin
        fpwm_mode = 1'b1;
        top = cmp_a_act_q; // RQ8
      end
      default: begin
        top = `COUNT_MAX; // RQ24
      end
    endcase
  end

  // Counter events, seen only on the timer tick
  wire run;
  wire at_top;
  wire at_max;
  wire eq_a;
  wire eq_b;
  assign run = tick & (ctc_mode | fpwm_mode); // RQ25 RQ24
  // Exact equality only: a TOP written below the count is missed
  assign at_top = run & (count_value_q == top); // RQ3 RQ13
  assign at_max = run & (count_value_q == `COUNT_MAX);
  assign eq_a = run & (count_value_q == cmp_a_act_q);
  assign eq_b = run & (count_value_q == cmp_b_act_q);

  // APB decode; zero-wait slave, write lands on the access edge
  wire setup;
  wire access;
  wire wr;
  reg mapped;
  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i & pready_o;
  assign wr = access & pwrite_i & ~pslverr_o;
  always @* begin
    case (paddr_i)
      `REG_CTRL, `REG_COUNT, `REG_CMP_A, `REG_CMP_B,
      `REG_CAP_TOP, `REG_FLAGS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Compare writes are cut to the fixed resolution
  wire [15:0] cmp_wdata;
  assign cmp_wdata = fixed_top ? (pwdata_i[15:0] & top)
                               : pwdata_i[15:0]; // RQ12

  // Read mux: compare registers read back the buffered value, masked to the fixed resolution when written
  reg [31:0] rdata;
  always @* begin
    rdata = 32'h0000_0000;
    case (paddr_i)
      `REG_CTRL: rdata = {18'h00000, ctrl_q};
      `REG_COUNT: rdata = {16'h0000, count_value_q};
      `REG_CMP_A: rdata = {16'h0000, cmp_a_buf_q};
      `REG_CMP_B: rdata = {16'h0000, cmp_b_buf_q};
      `REG_CAP_TOP: rdata = {16'h0000, capture_top_value_q};
      `REG_FLAGS: rdata = {28'h0000000, capture_flag_q,
                           match_b_flag_q, match_a_flag_q,
                           overflow_flag_q};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Bus answer registers
  always @(posedge clock_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup & ~mapped;
      if (setup) begin
        prdata_o <= mapped ? rdata : 32'h0000_0000;
      end
    end
  end

  // Control and capture TOP registers
  always @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_q <= `CTRL_RESET;
      capture_top_value_q <= `COUNT_ZERO;
    end else if (wr) begin
      if (paddr_i == `REG_CTRL) begin
        ctrl_q <= pwdata_i[13:0];
      end
      if (paddr_i == `REG_CAP_TOP) begin
        capture_top_value_q <= pwdata_i[15:0]; // RQ13
      end
    end
  end

  // Counter; a software write wins over the tick in the same cycle
  always @(posedge clock_i) begin
    if (rst_i) begin
      count_value_q <= `COUNT_ZERO;
    end else if (wr && paddr_i == `REG_COUNT) begin
      count_value_q <= pwdata_i[15:0];
    end else if (at_top) begin
      count_value_q <= `COUNT_ZERO; // RQ1 RQ8
    end else if (run) begin
      // Natural wrap through FFFF when TOP was missed
      count_value_q <= count_value_q + 16'h0001; // RQ3 RQ13 RQ25
    end
  end

  // Compare buffers; active copies follow directly outside PWM
  always @(posedge clock_i) begin
    if (rst_i) begin
      cmp_a_buf_q <= `COUNT_ZERO;
      cmp_b_buf_q <= `COUNT_ZERO;
      cmp_a_act_q <= `COUNT_ZERO;
      cmp_b_act_q <= `COUNT_ZERO;
    end else begin
      if (wr && paddr_i == `REG_CMP_A) begin
        cmp_a_buf_q <= cmp_wdata; // RQ23
      end
      if (wr && paddr_i == `REG_CMP_B) begin
        cmp_b_buf_q <= cmp_wdata;
      end
      if (!fpwm_mode) begin
        // No double buffering: the compare acts at once
        cmp_a_act_q <= (wr && paddr_i == `REG_CMP_A) ? cmp_wdata
                                                     : cmp_a_buf_q;
        cmp_b_act_q <= (wr && paddr_i == `REG_CMP_B) ? cmp_wdata
                                                     : cmp_b_buf_q;
      end else if (at_top) begin
        cmp_a_act_q <= cmp_a_buf_q; // RQ14
        cmp_b_act_q <= cmp_b_buf_q; // RQ14
      end
    end
  end

  // Flag causes for this tick
  wire ovf_set;
  wire cap_set;
  wire a_top_set;
  assign ovf_set = (ctc_mode & at_max) | (fpwm_mode & at_top); // RQ6 RQ11
  assign cap_set = at_top & (waveform_mode_sel == `MODE_CTC_CAP
                   || waveform_mode_sel == `MODE_FPWM_CAP); // RQ2 RQ11
  // TOP from compare A raises match A, together with overflow in fast PWM mode F, and in clear-on-match mode only when TOP is FFFF
  assign a_top_set = at_top & (waveform_mode_sel == `MODE_CTC_CMP
                     || waveform_mode_sel == `MODE_FPWM_CMP); // RQ2 RQ11

  // Write-one-to-clear flags; a set in the clearing cycle wins
  wire clr;
  assign clr = wr & (paddr_i == `REG_FLAGS);
  always @(posedge clock_i) begin
    if (rst_i) begin
      overflow_flag_q <= 1'b0;
      match_a_flag_q <= 1'b0;
      match_b_flag_q <= 1'b0;
      capture_flag_q <= 1'b0;
      match_a_pend_q <= 1'b0;
      match_b_pend_q <= 1'b0;
    end else begin
      // Plain matches wait one timer tick before flagging
      if (tick) begin
        match_a_pend_q <= eq_a & ~a_top_set; // RQ20 RQ25
        match_b_pend_q <= eq_b; // RQ20
      end
      overflow_flag_q <= ovf_set
        | (overflow_flag_q & ~(clr & pwdata_i[`FLAG_OVF]));
      capture_flag_q <= cap_set
        | (capture_flag_q & ~(clr & pwdata_i[`FLAG_CAPTURE]));
      match_a_flag_q <= a_top_set | (tick & match_a_pend_q)
        | (match_a_flag_q & ~(clr & pwdata_i[`FLAG_MATCH_A])); // RQ20
      match_b_flag_q <= (tick & match_b_pend_q)
        | (match_b_flag_q & ~(clr & pwdata_i[`FLAG_MATCH_B])); // RQ20
    end
  end

  // Next wave state for one channel
  function wave_next;
    input cur;
    input [1:0] om;
    input eq;
    input is_ctc;
    input is_pwm;
    input bottom;
    input tog_ok;
    begin
      wave_next = cur;
      if (is_ctc && eq) begin
        case (om)
          `OM_TOGGLE: wave_next = ~cur; // RQ4
          `OM_CLEAR: wave_next = 1'b0;
          `OM_SET: wave_next = 1'b1;
          default: wave_next = cur; // RQ22
        endcase
      end else if (is_pwm) begin
        case (om)
          `OM_TOGGLE: wave_next = (eq && tog_ok) ? ~cur : cur; // RQ16
          // BOTTOM wins over a match at TOP: constant level
          `OM_CLEAR: wave_next = bottom ? 1'b1
                       : (eq ? 1'b0 : cur); // RQ9 RQ10 RQ15
          `OM_SET: wave_next = bottom ? 1'b0
                     : (eq ? 1'b1 : cur); // RQ9 RQ10 RQ15
          default: wave_next = cur; // RQ22
        endcase
      end
    end
  endfunction

  // Wave state registers, zero after reset
  always @(posedge clock_i) begin
    if (rst_i) begin
      wave_out_a_q <= 1'b0; // RQ21
      wave_out_b_q <= 1'b0; // RQ21
    end else if (run) begin
      wave_out_a_q <= wave_next(wave_out_a_q, out_mode_a, eq_a,
        ctc_mode, fpwm_mode, at_top,
        waveform_mode_sel == `MODE_FPWM_CMP);
      wave_out_b_q <= wave_next(wave_out_b_q, out_mode_b, eq_b,
        ctc_mode, fpwm_mode, at_top, 1'b0);
    end
  end

  // Pin drivers; state is kept while the pin is an input
  always @(posedge clock_i) begin
    if (rst_i) begin
      wave_pin_a_o <= 1'b0;
      wave_pin_a_oe_o <= 1'b0;
      wave_pin_b_o <= 1'b0;
      wave_pin_b_oe_o <= 1'b0;
    end else begin
      wave_pin_a_o <= pin_dir_a & wave_out_a_q; // RQ5
      wave_pin_a_oe_o <= pin_dir_a; // RQ5
      wave_pin_b_o <= pin_dir_b & wave_out_b_q; // RQ5
      wave_pin_b_oe_o <= pin_dir_b; // RQ5
    end
  end

endmodule

// ===== bench/timer16_pwm_sva.sv
// Port-level assertions for the 16-bit PWM timer block
`timescale 1ns/1ps
`include "timer16_regs.vh"

module timer16_pwm_sva (
  // Clock and reset
  input logic clock_i,
  input logic rst_i,
  // APB slave
  input logic psel_i,
  input logic penable_i,
  input logic pwrite_i,
  input logic [7:0] paddr_i,
  input logic [31:0] pwdata_i,
  input logic [31:0] prdata_o,
  input logic pready_o,
  input logic pslverr_o,
  // Compare output pins
  input logic wave_pin_a_o,
  input logic wave_pin_a_oe_o,
  input logic wave_pin_b_o,
  input logic wave_pin_b_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // Zero wait states: ready always follows a setup cycle
  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("ready missing after setup");
  a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access phase");
  a_ready_one_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_err_unmapped: assert property (pready_o && paddr_i > `REG_FLAGS
    |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
    else $error("unmapped access not refused");
  // A pin not set as output must never show the wave state
  a_pin_a_idle: assert property (!wave_pin_a_oe_o |-> !wave_pin_a_o)
    else $error("pin a driven while not output");
  a_pin_b_idle: assert property (!wave_pin_b_oe_o |-> !wave_pin_b_o)
    else $error("pin b driven while not output");
  a_dir_follows_ctrl: assert property (pready_o && pwrite_i &&
    paddr_i == `REG_CTRL |-> ##2 wave_pin_a_oe_o == $past(pwdata_i[12], 2))
    else $error("pin a enable does not follow direction bit");
  // Reset must be observed even though the default disable is reset
  a_reset_clears: assert property (disable iff (1'b0) rst_i |=>
    !wave_pin_a_o && !wave_pin_a_oe_o && !wave_pin_b_o && !pready_o)
    else $error("outputs not cleared by reset");

  c_unmapped: cover property (pready_o && pslverr_o);
  c_pin_rise: cover property (wave_pin_a_oe_o ##1 $rose(wave_pin_a_o));
  c_pin_fall: cover property (wave_pin_a_oe_o ##1 $fell(wave_pin_a_o));
endmodule

bind timer16_ctc_fast_pwm timer16_pwm_sva chk (.clock_i(clock_i),
  .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .wave_pin_a_o(wave_pin_a_o), .wave_pin_a_oe_o(wave_pin_a_oe_o),
  .wave_pin_b_o(wave_pin_b_o), .wave_pin_b_oe_o(wave_pin_b_oe_o));

// ===== bench/timer16_ctc_fast_pwm_tb.sv
// Self-checking bench for the 16-bit PWM timer block
`timescale 1ns/1ps
`include "timer16_regs.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end

module timer16_ctc_fast_pwm_tb;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, q;
  logic pready_o, pslverr_o, err, pa, pa_oe, pb, pb_oe;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;
  int hi, lo, c;

  timer16_ctc_fast_pwm dut (.clock_i(clock_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .wave_pin_a_o(pa),
    .wave_pin_a_oe_o(pa_oe), .wave_pin_b_o(pb), .wave_pin_b_oe_o(pb_oe));

  always #2.5 clock_i = ~clock_i;

  // Hang guard: the whole run needs far fewer clocks than this
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      conclude();
    end
  end

  // One APB transfer, entered and left right after a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1) @(posedge clock_i);
    q = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask

  // Counts clocks until pin A shows level v, capped to stay bounded
  task run_until(input logic v, output int n);
    n = 0;
    while (pa !== v && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
  endtask

  // High and low time of pin A, after skipping one partial cycle
  task measure;
    run_until(1'b0, c);
    run_until(1'b1, c);
    run_until(1'b0, hi);
    run_until(1'b1, lo);
  endtask

  task cfg(input logic [3:0] m, input logic [1:0] om, input logic [2:0] pre,
           input logic [15:0] cmp, input logic [15:0] top);
    apb(1'b1, `REG_CTRL, {18'h0, 2'b01, 1'b0, pre, 2'h0, om, m});
    apb(1'b1, `REG_CMP_A, {16'h0, cmp});
    apb(1'b1, `REG_CAP_TOP, {16'h0, top});
    apb(1'b1, `REG_COUNT, 32'h0);
  endtask

  // Fast PWM run; measured twice so a stale buffered compare drains
  task fp(input logic [3:0] m, input logic [1:0] om, input logic [15:0] cmp,
          input logic [15:0] top, input int ehi, input int eper);
    cfg(m, om, `PRE_DIV1, cmp, top);
    measure();
    measure();
    `CHK(hi, ehi)
    `CHK(hi + lo, eper)
  endtask

  task t_reset;
    `CHK({pa, pa_oe, pb, pb_oe}, 4'h0)
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHK(q, 32'h0)
    apb(1'b1, 8'h40, 32'hFFFF);
    apb(1'b0, 8'h40, 32'h0);
    `CHK({err, q}, {1'b1, 32'h0})
  endtask

  task t_ctc;
    cfg(`MODE_CTC_CMP, `OM_TOGGLE, `PRE_DIV1, 16'h4, 16'h0);
    measure();
    `CHK(hi, 5)
    `CHK(hi + lo, 10)
    apb(1'b0, `REG_FLAGS, 32'h0);
    `CHK(q[`FLAG_MATCH_A], 1'b1)
    cfg(`MODE_CTC_CAP, `OM_TOGGLE, `PRE_DIV1, 16'h6, 16'h6);
    apb(1'b1, `REG_FLAGS, 32'hF);
    measure();
    `CHK(hi, 7)
    apb(1'b0, `REG_FLAGS, 32'h0);
    `CHK(q[`FLAG_CAPTURE], 1'b1)
    cfg(`MODE_CTC_CMP, `OM_TOGGLE, `PRE_DIV8, 16'h4, 16'h0);
    measure();
    `CHK(hi + lo, 80)
  endtask

  // TOP written below the count is missed and the counter wraps
  task t_wrap;
    cfg(`MODE_CTC_CAP, `OM_NONE, `PRE_DIV1, 16'h0, 16'h10);
    apb(1'b1, `REG_COUNT, 32'h20);
    apb(1'b0, `REG_COUNT, 32'h0);
    `CHK(q[15:0] > 16'h0020, 1'b1)
    apb(1'b1, `REG_FLAGS, 32'hF);
    apb(1'b1, `REG_COUNT, 32'hFFF0);
    repeat (30) @(posedge clock_i);
    apb(1'b0, `REG_FLAGS, 32'h0);
    `CHK(q[`FLAG_OVF], 1'b1)
    apb(1'b0, `REG_COUNT, 32'h0);
    `CHK(q[15:0] < 16'h0011, 1'b1)
  endtask

  task t_fpwm;
    fp(`MODE_FPWM_8, `OM_CLEAR, 16'h40, 16'h0, 'h41, 256);
    fp(`MODE_FPWM_8, `OM_SET, 16'h40, 16'h0, 'hBF, 256);
    fp(`MODE_FPWM_8, `OM_CLEAR, 16'h0, 16'h0, 1, 256);
    fp(`MODE_FPWM_9, `OM_CLEAR, 16'h100, 16'h0, 'h101, 512);
    fp(`MODE_FPWM_10, `OM_CLEAR, 16'h10, 16'h0, 'h11, 1024);
    fp(`MODE_FPWM_CMP, `OM_TOGGLE, 16'h7, 16'h0, 8, 16);
    fp(`MODE_FPWM_CMP, `OM_TOGGLE, 16'hB, 16'h0, 12, 24);
    apb(1'b1, `REG_FLAGS, 32'hF);
    fp(`MODE_FPWM_CAP, `OM_CLEAR, 16'h3, 16'h9, 4, 10);
    apb(1'b0, `REG_FLAGS, 32'h0);
    `CHK(q[3:0] & 4'h9, 4'h9)
    // Compare equal to TOP holds the pin high without a gap
    cfg(`MODE_FPWM_8, `OM_CLEAR, `PRE_DIV1, 16'hFF, 16'h0);
    run_until(1'b1, c);
    run_until(1'b0, c);
    `CHK(c, 3000)
  endtask

  // Compare writes lose bits above a fixed resolution
  task t_mask;
    logic [15:0] tops [3];
    tops = '{`TOP_8BIT, `TOP_9BIT, `TOP_10BIT};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `REG_CTRL, {28'h0, `MODE_FPWM_8 + 4'(i)});
      apb(1'b1, `REG_CMP_B, 32'hFFFF);
      apb(1'b0, `REG_CMP_B, 32'h0);
      `CHK(q, {16'h0, tops[i]})
    end
  endtask

  task t_pin;
    apb(1'b1, `REG_CTRL, {18'h0, 2'b00, 1'b0, `PRE_DIV1, 2'h0, `OM_TOGGLE,
                          `MODE_CTC_CMP});
    apb(1'b1, `REG_CMP_A, 32'h4);
    repeat (20) @(posedge clock_i);
    `CHK({pa, pa_oe}, 2'b00)
    cfg(`MODE_CTC_CMP, `OM_NONE, `PRE_DIV1, 16'h4, 16'h0);
    run_until(~pa, c);
    `CHK(c, 3000)
    // Stopped timer: write-one clears every flag
    apb(1'b1, `REG_CTRL, 32'h0);
    apb(1'b1, `REG_FLAGS, 32'hF);
    apb(1'b0, `REG_FLAGS, 32'h0);
    `CHK(q[3:0], 4'h0)
  endtask

  // A plain match flags one tick late; the slow divide makes the gap visible
  task t_flag_delay;
    apb(1'b1, `REG_CTRL, {28'h0, `MODE_CTC_CMP});
    apb(1'b1, `REG_CMP_A, 32'h20);
    apb(1'b1, `REG_CMP_B, 32'h5);
    apb(1'b1, `REG_COUNT, 32'h5);
    apb(1'b1, `REG_FLAGS, 32'hF);
    apb(1'b1, `REG_CTRL, {21'h0, `PRE_DIV1024, 4'h0, `MODE_CTC_CMP});
    repeat (1500) @(posedge clock_i);
    apb(1'b0, `REG_FLAGS, 32'h0);
    `CHK(q[`FLAG_MATCH_B], 1'b0)
    apb(1'b0, `REG_COUNT, 32'h0);
    `CHK(q[15:0], 16'h0006)
    repeat (1000) @(posedge clock_i);
    apb(1'b0, `REG_FLAGS, 32'h0);
    `CHK(q[`FLAG_MATCH_B], 1'b1)
  endtask

  // Channel B inverting PWM; any two whole periods hold the same high time
  task t_chan_b;
    int n;
    apb(1'b1, `REG_CTRL, {18'h0, 2'b10, 1'b0, `PRE_DIV1, `OM_SET, `OM_NONE,
                          `MODE_FPWM_8});
    apb(1'b1, `REG_CMP_B, 32'h40);
    repeat (600) @(posedge clock_i);
    n = 0;
    repeat (512) begin
      @(posedge clock_i);
      if (pb === 1'b1) begin
        n++;
      end
    end
    `CHK(n, 2 * (`TOP_8BIT - 16'h0040))
    `CHK(pb_oe, 1'b1)
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    t_reset();
    t_ctc();
    t_wrap();
    t_fpwm();
    t_mask();
    t_pin();
    t_flag_delay();
    t_chan_b();
    conclude();
  end
endmodule
